// ===== core/dual_sync_serial_port.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Each port has separate double-buffered transmit and receive sections.
// - Bit clock comes from an internal divider or from the clock pin.
// - Receive framing is configured apart from transmit framing.
// - Frameless continuous words, or framed with internal or external sync.
// - Frame sync polarity selectable; normal (early) or late pulse timing.
// - Word length programmable from 3 to 16 bits per section.
// - Optional mu-law or A-law: expand on receive, compress on transmit.
// - Each section pulses its own word-complete interrupt.
// - Auto-buffering moves a whole buffer, one overhead cycle per word.
// - With auto-buffering, one interrupt per buffer instead of per word.
// - Port a multichannel: 24 or 32 slot frame, selected slots only.
// - Port b pins may become two interrupt inputs and flag in/out.
// - Internal serial clock output stays usable in that alternate mode.
// - Alternate interrupt inputs are edge or level sensitive each.
// - Pin functions change from configuration at any time, not only reset.
// - Each port uses clock, two frame syncs, receive and transmit data.
`include "dual_sport_map.svh"

module dual_sync_serial_port #(
    parameter int MC_PORT = 0,
    parameter int ALT_PORT = 1
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire dual_sport_pkg::pin_in_t [1:0] pin_i,
    output wire dual_sport_pkg::pin_out_t [1:0] pin_o,
    input wire dual_sport_pkg::port_cfg_t [1:0] cfg_i,
    input wire logic [1:0][15:0] tx_data_i,
    input wire logic [1:0] tx_wr_i,
    output wire logic [1:0] tx_full_o,
    output wire logic [1:0][15:0] rx_data_o,
    output wire logic [1:0] rx_full_o,
    input wire logic [1:0] rx_rd_i,
    output wire logic [1:0][1:0] word_irq_o,
    output wire logic [1:0][1:0] buf_irq_o,
    input wire logic alt_mode_i,
    input wire logic [1:0] alt_edge_i,
    input wire logic serial_flag_output_i,
    output logic alt_interrupt_in_zero_o,
    output logic alt_interrupt_in_one_o,
    output logic serial_flag_input_o
);

    // ------------------------------------------------------------------
    // Companding
    // ------------------------------------------------------------------
    function automatic logic [7:0] mu_compress(input logic [15:0] lin);
        logic [13:0] s;
        logic [13:0] mag;
        logic [2:0] seg;
        s = lin[15:2];
        mag = s[13] ? 14'(-s) : s;
        if (mag > `MU_CLIP) begin
            mag = `MU_CLIP;
        end
        mag = mag + `MU_BIAS;
        seg = 3'h0;
        for (int b = 1; b < 8; b++) begin
            if (mag[b + 5]) begin
                seg = 3'(b);
            end
        end
        return ~{s[13], seg, mag[{1'b0, seg} + 4'h1 +: 4]};
    endfunction

    function automatic logic [15:0] mu_expand(input logic [7:0] code);
        logic [7:0] c;
        logic [15:0] t;
        c = ~code;
        t = ({9'h000, c[3:0], 3'h0} + `MU_DEC_BIAS) << c[6:4];
        t = t - `MU_DEC_BIAS;
        return c[7] ? 16'(-t) : t;
    endfunction

    function automatic logic [7:0] a_compress(input logic [15:0] lin);
        logic [12:0] s;
        logic [12:0] mag;
        logic [2:0] seg;
        logic [3:0] man;
        s = lin[15:3];
        mag = s[12] ? ~s : s;
        seg = 3'h0;
        for (int b = 0; b < 7; b++) begin
            if (mag[b + 5]) begin
                seg = 3'(b + 1);
            end
        end
        man = (seg < 3'h2) ? mag[4:1] : mag[seg +: 4];
        return {~s[12], seg, man} ^ `A_XOR;
    endfunction

    function automatic logic [15:0] a_expand(input logic [7:0] code);
        logic [7:0] c;
        logic [15:0] t;
        c = code ^ `A_XOR;
        t = {8'h00, c[3:0], 4'h0} + `A_HALF;
        if (c[6:4] != 3'h0) begin
            t = (t + `A_SEG1) << (c[6:4] - 3'h1);
        end
        return c[7] ? t : 16'(-t);
    endfunction

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (MC_PORT < 0 || MC_PORT > 1 || ALT_PORT < 0 || ALT_PORT > 1 ||
        MC_PORT == ALT_PORT) begin : g_bad_param
        $error("MC_PORT and ALT_PORT must be distinct ports 0 or 1");
    end

    // Pins pass two flip-flops; the third stage only feeds edge detectors
    dual_sport_pkg::pin_in_t sy_m_r [2], sy_s_r [2], sy_d_r [2];

    // ------------------------------------------------------------------
    // Ports
    // ------------------------------------------------------------------
    for (genvar p = 0; p < 2; p++) begin : g_port
        dual_sport_pkg::port_cfg_t cfg;
        dual_sport_pkg::pin_out_t pin_r, pin_nxt;
        logic alt, mc, tick, rise, fall, sclk_int_r, tx_full_r, rx_full_r;
        logic [7:0] div_cnt_r, tx_code;
        logic busy_r [2], armed_r [2], sel_r [2], fs_out_r [2], gen_w [2];
        logic word_irq_r [2], buf_irq_r [2], load_w [2], done_w [2];
        logic [3:0] cnt_r [2];
        logic [4:0] slot_r [2];
        logic [15:0] shreg_r [2];
        logic [7:0] wc_r [2];
        logic [15:0] tx_hold_r, rx_hold_r, tx_word, rx_word;

        assign cfg = cfg_i[p];
        assign alt = (p == ALT_PORT) && alt_mode_i;
        assign mc = (p == MC_PORT) && cfg.mc_en;

        // Bit clock: internal divider or synchronised pin edges
        assign tick = cfg.int_clk & (div_cnt_r == cfg.clk_div);
        assign rise = cfg.int_clk ? (tick & !sclk_int_r)
                                  : (sy_s_r[p].sclk & !sy_d_r[p].sclk);
        assign fall = cfg.int_clk ? (tick & sclk_int_r)
                                  : (!sy_s_r[p].sclk & sy_d_r[p].sclk);

        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                sy_m_r[p] <= '0;
                sy_s_r[p] <= '0;
                sy_d_r[p] <= '0;
            end else begin
                sy_m_r[p] <= pin_i[p];
                sy_s_r[p] <= sy_m_r[p];
                sy_d_r[p] <= sy_s_r[p];
            end
        end

        // Divider keeps running in alternate mode so the clock stays out
        always_ff @(posedge clock_i) begin
            if (srst_i || !cfg.int_clk) begin
                div_cnt_r <= 8'h00;
                sclk_int_r <= 1'b0;
            end else if (tick) begin
                div_cnt_r <= 8'h00;
                sclk_int_r <= !sclk_int_r;
            end else begin
                div_cnt_r <= div_cnt_r + 8'h01;
            end
        end

        // Companding on the buffer side of the shifters
        assign tx_code = (cfg.compand == dual_sport_pkg::COMPAND_MU)
                         ? mu_compress(tx_hold_r) : a_compress(tx_hold_r);
        assign tx_word = !tx_full_r ? 16'h0000
                       : (cfg.compand == dual_sport_pkg::COMPAND_OFF)
                         ? tx_hold_r : {8'h00, tx_code};
        assign rx_word = (cfg.compand == dual_sport_pkg::COMPAND_MU)
                         ? mu_expand(shreg_r[1][7:0])
                       : (cfg.compand == dual_sport_pkg::COMPAND_A)
                         ? a_expand(shreg_r[1][7:0]) : shreg_r[1];

        // --------------------------------------------------------------
        // Sections: 0 transmits on rising edges, 1 samples on falling
        // --------------------------------------------------------------
        for (genvar s = 0; s < 2; s++) begin : g_sect
            dual_sport_pkg::sect_cfg_t sc;
            logic edge_w, en, framed, late, src_int, pin_fs, hit, free, cont;
            logic in_frame, data_ok, begin_w, arm_set, sel_nxt, buf_end;
            logic [3:0] wlen;
            logic [4:0] last_slot, slot_nxt;
            logic [7:0] wc_nxt;

            assign sc = (s == 1) ? cfg.rx : cfg.tx;
            assign edge_w = (s == 1) ? fall : rise;
            assign en = sc.en & !alt;
            assign framed = sc.framed | mc;
            assign late = sc.late_fs | !framed;
            assign wlen = (sc.wlen_m1 < `WLEN_MIN_M1)
                          ? `WLEN_MIN_M1 : sc.wlen_m1;
            assign last_slot = cfg.mc_32 ? `MC_LAST_32 : `MC_LAST_24;
            assign in_frame = mc & busy_r[s] & (slot_r[s] != last_slot);
            assign free = !busy_r[s] | (cnt_r[s] == 4'h0);
            assign cont = in_frame & (cnt_r[s] == 4'h0);
            assign data_ok = (s == 1) | mc | tx_full_r;

            // In multichannel mode both sections follow the receive sync
            assign src_int = mc ? cfg.rx.int_fs : sc.int_fs;
            assign pin_fs = (mc || s == 1)
                            ? (sy_s_r[p].rfs ^ cfg.rx.fs_inv)
                            : (sy_s_r[p].tfs ^ cfg.tx.fs_inv);
            assign gen_w[s] = en & framed & sc.int_fs & (!mc | (s == 1))
                              & free & !armed_r[s] & !fs_out_r[s]
                              & !in_frame & data_ok;
            assign hit = !framed ? data_ok
                       : !src_int ? pin_fs
                       : (s == 1) ? fs_out_r[1]
                       : (mc ? gen_w[1] : gen_w[0]);

            assign begin_w = en & free & data_ok
                             & (armed_r[s] | (late & hit) | cont);
            assign arm_set = en & free & hit & !late & !cont;
            assign slot_nxt = cont ? (slot_r[s] + 5'h01) : 5'h00;
            assign sel_nxt = !mc | cfg.slot_mask[slot_nxt];
            assign done_w[s] = edge_w & en & busy_r[s]
                               & (cnt_r[s] == 4'h0) & sel_r[s];
            assign load_w[s] = edge_w & begin_w & sel_nxt;
            assign wc_nxt = wc_r[s] + 8'h01;
            assign buf_end = (wc_nxt >= cfg.buf_len);

            always_ff @(posedge clock_i) begin
                if (srst_i || !en) begin
                    busy_r[s] <= 1'b0;
                    armed_r[s] <= 1'b0;
                    sel_r[s] <= 1'b0;
                    cnt_r[s] <= 4'h0;
                    slot_r[s] <= 5'h00;
                    shreg_r[s] <= 16'h0000;
                end else if (edge_w) begin
                    armed_r[s] <= !begin_w & (armed_r[s] | arm_set);
                    if (begin_w) begin
                        busy_r[s] <= 1'b1;
                        cnt_r[s] <= wlen;
                        slot_r[s] <= slot_nxt;
                        sel_r[s] <= sel_nxt;
                        // Receive starts cleared so short words sit low
                        shreg_r[s] <= (s == 1)
                            ? {15'h0000, sy_s_r[p].dr} : tx_word;
                    end else if (busy_r[s] && cnt_r[s] != 4'h0) begin
                        cnt_r[s] <= cnt_r[s] - 4'h1;
                        if (s == 1) begin
                            shreg_r[s] <= {shreg_r[s][14:0], sy_s_r[p].dr};
                        end
                    end else begin
                        busy_r[s] <= 1'b0;
                    end
                end
            end

            // Sync pulse lasts one bit period, launched on a rising edge
            always_ff @(posedge clock_i) begin
                if (srst_i || !en) begin
                    fs_out_r[s] <= 1'b0;
                end else if (rise) begin
                    fs_out_r[s] <= gen_w[s];
                end
            end

            // The only core cycle a word costs is this completion strobe
            always_ff @(posedge clock_i) begin
                if (srst_i) begin
                    word_irq_r[s] <= 1'b0;
                    buf_irq_r[s] <= 1'b0;
                    wc_r[s] <= 8'h00;
                end else begin
                    word_irq_r[s] <= done_w[s] & !cfg.autobuf;
                    buf_irq_r[s] <= done_w[s] & cfg.autobuf & buf_end;
                    if (!cfg.autobuf) begin
                        wc_r[s] <= 8'h00;
                    end else if (done_w[s]) begin
                        wc_r[s] <= buf_end ? 8'h00 : wc_nxt;
                    end
                end
            end

            assign word_irq_o[p][s] = word_irq_r[s];
            assign buf_irq_o[p][s] = buf_irq_r[s];
        end

        // --------------------------------------------------------------
        // Holding buffers; a new event beats a clear in the same cycle
        // --------------------------------------------------------------
        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                tx_hold_r <= 16'h0000;
                tx_full_r <= 1'b0;
            end else if (tx_wr_i[p]) begin
                tx_hold_r <= tx_data_i[p];
                tx_full_r <= 1'b1;
            end else if (load_w[0]) begin
                tx_full_r <= 1'b0;
            end
        end

        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                rx_hold_r <= 16'h0000;
                rx_full_r <= 1'b0;
            end else if (done_w[1]) begin
                rx_hold_r <= rx_word;
                rx_full_r <= 1'b1;
            end else if (rx_rd_i[p]) begin
                rx_full_r <= 1'b0;
            end
        end

        // --------------------------------------------------------------
        // Pin drivers, re-timed so every pin leaves a flip-flop
        // --------------------------------------------------------------
        assign pin_nxt.sclk = sclk_int_r;
        assign pin_nxt.sclk_oe = cfg.int_clk;
        assign pin_nxt.rfs = fs_out_r[1] ^ cfg.rx.fs_inv;
        assign pin_nxt.rfs_oe = !alt & cfg.rx.en & cfg.rx.int_fs
                                & (cfg.rx.framed | mc);
        assign pin_nxt.tfs = fs_out_r[0] ^ cfg.tx.fs_inv;
        assign pin_nxt.tfs_oe = !alt & !mc & cfg.tx.en & cfg.tx.int_fs
                                & cfg.tx.framed;
        assign pin_nxt.dt = alt ? serial_flag_output_i
                                : shreg_r[0][cnt_r[0]];
        assign pin_nxt.dt_oe = alt | (busy_r[0] & sel_r[0]);

        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                pin_r <= '0;
            end else begin
                pin_r <= pin_nxt;
            end
        end

        assign pin_o[p] = pin_r;
        assign tx_full_o[p] = tx_full_r;
        assign rx_full_o[p] = rx_full_r;
        assign rx_data_o[p] = rx_hold_r;
    end

    // ------------------------------------------------------------------
    // Alternate function of port b: active-low requests and flag input
    // ------------------------------------------------------------------
    logic alt_interrupt_in_zero_nxt, alt_interrupt_in_one_nxt;

    assign alt_interrupt_in_zero_nxt = alt_edge_i[0]
                      ? (!sy_s_r[ALT_PORT].rfs & sy_d_r[ALT_PORT].rfs)
                      : !sy_s_r[ALT_PORT].rfs;
    assign alt_interrupt_in_one_nxt = alt_edge_i[1]
                      ? (!sy_s_r[ALT_PORT].tfs & sy_d_r[ALT_PORT].tfs)
                      : !sy_s_r[ALT_PORT].tfs;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            alt_interrupt_in_zero_o <= 1'b0;
            alt_interrupt_in_one_o <= 1'b0;
            serial_flag_input_o <= 1'b0;
        end else begin
            alt_interrupt_in_zero_o <= alt_mode_i & alt_interrupt_in_zero_nxt;
            alt_interrupt_in_one_o <= alt_mode_i & alt_interrupt_in_one_nxt;
            serial_flag_input_o <= alt_mode_i & sy_s_r[ALT_PORT].dr;
        end
    end

endmodule // dual_sync_serial_port

// ===== core/dual_sport_map.svh
`ifndef DUAL_SPORT_MAP_SVH
`define DUAL_SPORT_MAP_SVH

// ----------------------------------------------------------------------
// Word length
// ----------------------------------------------------------------------
// Shortest word is 3 bits, kept as length minus one
`define WLEN_MIN_M1 4'h2
`define WLEN_MAX_M1 4'hF

// ----------------------------------------------------------------------
// Multichannel frame, last slot index
// ----------------------------------------------------------------------
`define MC_LAST_24 5'h17
`define MC_LAST_32 5'h1F

// ----------------------------------------------------------------------
// Logarithmic companding constants
// ----------------------------------------------------------------------
`define MU_CLIP 14'h1FDE
`define MU_BIAS 14'h0021
`define MU_DEC_BIAS 16'h0084
`define A_XOR 8'h55
`define A_HALF 16'h0008
`define A_SEG1 16'h0100

`endif

// ===== core/dual_sport_pkg.sv
package dual_sport_pkg;

    // ------------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        COMPAND_OFF,
        COMPAND_MU,
        COMPAND_A
    } compand_t;

    typedef struct packed {
        logic en;
        logic framed;
        logic int_fs;
        logic fs_inv;
        logic late_fs;
        logic [3:0] wlen_m1;
    } sect_cfg_t;

    typedef struct packed {
        logic int_clk;
        logic [7:0] clk_div;
        compand_t compand;
        logic autobuf;
        logic [7:0] buf_len;
        logic mc_en;
        logic mc_32;
        logic [31:0] slot_mask;
        sect_cfg_t rx;
        sect_cfg_t tx;
    } port_cfg_t;

    // ------------------------------------------------------------------
    // Pins of one port
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sclk;
        logic rfs;
        logic tfs;
        logic dr;
    } pin_in_t;

    typedef struct packed {
        logic sclk;
        logic sclk_oe;
        logic rfs;
        logic rfs_oe;
        logic tfs;
        logic tfs_oe;
        logic dt;
        logic dt_oe;
    } pin_out_t;

endpackage

// ===== verification/dual_sport_properties.sv
`timescale 1ns/100ps
module dual_sport_properties (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire dual_sport_pkg::pin_in_t [1:0] pin_i,
    input wire dual_sport_pkg::pin_out_t [1:0] pin_o,
    input wire dual_sport_pkg::port_cfg_t [1:0] cfg_i,
    input wire logic [1:0] tx_wr_i,
    input wire logic [1:0] tx_full_o,
    input wire logic [1:0] rx_full_o,
    input wire logic [1:0] rx_rd_i,
    input wire logic [1:0][1:0] word_irq_o,
    input wire logic [1:0][1:0] buf_irq_o,
    input wire logic alt_mode_i,
    input wire logic [1:0] alt_edge_i,
    input wire logic serial_flag_output_i,
    input wire logic alt_interrupt_in_one_o,
    input wire logic alt_interrupt_in_zero_o,
    input wire logic serial_flag_input_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (srst_i);
    chk_tx_full_set: assert property (tx_wr_i[0] |=> tx_full_o[0])
        else $error("tx buffer not full after write");
    chk_rx_rd_clear: assert property (rx_rd_i[0] && !cfg_i[0].autobuf
        |=> !rx_full_o[0] || word_irq_o[0][1])
        else $error("rx buffer still full after read");
    chk_word_irq_pulse: assert property (word_irq_o[0][1]
        |-> rx_full_o[0] ##1 !word_irq_o[0][1])
        else $error("rx word irq not a single pulse with data");
    chk_autobuf_quiet: assert property
        (cfg_i[0].autobuf && $past(cfg_i[0].autobuf) |-> word_irq_o[0] == 2'b00)
        else $error("word irq raised while auto buffering");
    chk_buf_irq_mode: assert property
        (!cfg_i[0].autobuf && !$past(cfg_i[0].autobuf) |-> buf_irq_o[0] == 2'b00)
        else $error("buffer irq raised without auto buffering");
    chk_reset_quiet: assert property (disable iff (1'b0) srst_i
        |=> pin_o == '0 && tx_full_o == 2'b00 && rx_full_o == 2'b00)
        else $error("outputs not quiet after reset");
    chk_alt_level_irq: assert property
        ((alt_mode_i && !alt_edge_i[0] && !pin_i[1].rfs)[*4]
        |-> alt_interrupt_in_zero_o)
        else $error("level interrupt input not seen");
    chk_alt_edge_pulse: assert property
        (alt_interrupt_in_one_o && alt_edge_i[1] && $past(alt_edge_i[1])
        |=> !alt_interrupt_in_one_o)
        else $error("edge interrupt longer than one cycle");
    chk_alt_flag_out: assert property
        ((alt_mode_i && $stable(serial_flag_output_i))[*3]
        |-> pin_o[1].dt_oe && pin_o[1].dt == serial_flag_output_i)
        else $error("flag output not on transmit pin");
    chk_alt_sclk_kept: assert property
        ((alt_mode_i && cfg_i[1].int_clk)[*3] |-> pin_o[1].sclk_oe)
        else $error("internal serial clock lost in alternate mode");
    chk_flag_in_idle: assert property
        ((!alt_mode_i)[*2] |-> !serial_flag_input_o)
        else $error("flag input active outside alternate mode");
    cover property (buf_irq_o[0][0]);
    cover property (word_irq_o[0][1]);
    cover property (alt_interrupt_in_one_o);
endmodule // dual_sport_properties

bind dual_sync_serial_port dual_sport_properties i_dual_sport_properties (
    .clock_i, .srst_i, .pin_i, .pin_o, .cfg_i, .tx_wr_i, .tx_full_o,
    .rx_full_o, .rx_rd_i, .word_irq_o, .buf_irq_o, .alt_mode_i, .alt_edge_i,
    .serial_flag_output_i, .alt_interrupt_in_one_o, .alt_interrupt_in_zero_o,
    .serial_flag_input_o
);

// ===== verification/sport_far_end.sv
`timescale 1ns/100ps
module sport_far_end (
    input wire logic dt_i,
    output logic sclk_o,
    output logic rfs_o,
    output logic tfs_o,
    output logic dr_o
);
    initial begin
        sclk_o = 1'b0;
        rfs_o = 1'b0;
        tfs_o = 1'b0;
        dr_o = 1'b0;
    end
    // Clock runs only inside the frame; sync and data move a quarter
    // period after the rise so both sampling edges see them settled
    task automatic xfer(input int wlen, input logic late, input logic inv,
        input logic [15:0] rx_word, output logic [15:0] tx_word);
        int k;
        tx_word = 16'h0000;
        rfs_o = inv;
        tfs_o = inv;
        #200;
        for (int c = 0; c < wlen + 4; c++) begin
            sclk_o = 1'b1;
            #100;
            rfs_o = inv ^ (c == 0);
            tfs_o = inv ^ (c == 0);
            k = late ? c : c - 1;
            dr_o = (k >= 0 && k < wlen) ? rx_word[wlen - 1 - k] : ~dr_o;
            #100;
            sclk_o = 1'b0;
            #199;
            if (c >= 2 && c < wlen + 2) begin
                tx_word = {tx_word[14:0], dt_i};
            end
            #1;
        end
    endtask
endmodule // sport_far_end

// ===== verification/tb.sv
`timescale 1ns/100ps
module tb;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    dual_sport_pkg::port_cfg_t [1:0] cfg;
    dual_sport_pkg::pin_in_t [1:0] pin_in;
    dual_sport_pkg::pin_out_t [1:0] pin_out;
    dual_sport_pkg::pin_in_t pin_b;
    logic [1:0][15:0] tx_data, rx_data;
    logic [1:0] tx_wr, tx_full, rx_full, rx_rd, alt_edge;
    logic [1:0][1:0] word_irq, buf_irq;
    logic alt_mode, flag_out, irq_zero, irq_one, flag_in;
    logic far_sclk, far_rfs, far_tfs, far_dr;
    int mismatches = 0;
    int samples_checked = 0;
    int seed = 5;
    int wc[2] = '{0, 0};
    int bc[2] = '{0, 0};
    int lens[4] = '{3, 16, 8, 11};
    int pulses = 0;
    int exp_w = 0;
    always #25 clock_i = ~clock_i;
    assign pin_in[0] = {far_sclk, far_rfs, far_tfs, far_dr};
    // Shared clock pin: our driver wins only while the port lets go
    assign pin_in[1] = {pin_out[1].sclk_oe ? pin_out[1].sclk : pin_b.sclk,
        pin_b.rfs, pin_b.tfs, pin_b.dr};
    dual_sync_serial_port i_dual_sync_serial_port (.clock_i(clock_i),
        .srst_i(srst_i), .pin_i(pin_in), .pin_o(pin_out), .cfg_i(cfg),
        .tx_data_i(tx_data), .tx_wr_i(tx_wr), .tx_full_o(tx_full),
        .rx_data_o(rx_data), .rx_full_o(rx_full), .rx_rd_i(rx_rd),
        .word_irq_o(word_irq), .buf_irq_o(buf_irq), .alt_mode_i(alt_mode),
        .alt_edge_i(alt_edge), .serial_flag_output_i(flag_out),
        .alt_interrupt_in_zero_o(irq_zero), .alt_interrupt_in_one_o(irq_one),
        .serial_flag_input_o(flag_in));
    // A released data pin reads inverted, so a stray sample shows up
    sport_far_end i_sport_far_end (.dt_i(pin_out[0].dt ^ !pin_out[0].dt_oe),
        .sclk_o(far_sclk), .rfs_o(far_rfs), .tfs_o(far_tfs), .dr_o(far_dr));
    always @(posedge clock_i) begin
        for (int s = 0; s < 2; s++) begin
            if (word_irq[0][s] === 1'b1) wc[s]++;
            if (buf_irq[0][s] === 1'b1) bc[s]++;
        end
        if (irq_one === 1'b1) pulses++;
    end
    task automatic compare(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One framed word each way through the far end, then the read-back
    task automatic word(input int wlen, input logic late, input logic inv,
        input dual_sport_pkg::compand_t cmp);
        logic [15:0] tx_w, rx_w, got, mask, tx_e, rx_e;
        mask = 16'hFFFF >> (16 - wlen);
        tx_w = 16'($random(seed));
        rx_w = 16'($random(seed));
        tx_e = tx_w & mask;
        rx_e = rx_w & mask;
        // Full-scale pairs: most negative sample out, top code in
        if (cmp == dual_sport_pkg::COMPAND_MU) begin
            {tx_w, rx_w, tx_e, rx_e} = 64'h8000_0080_0000_7D7C;
        end else if (cmp == dual_sport_pkg::COMPAND_A) begin
            {tx_w, rx_w, tx_e, rx_e} = 64'h8000_00AA_002A_7E00;
        end
        cfg[0].compand = cmp;
        cfg[0].rx.wlen_m1 = 4'(wlen - 1);
        cfg[0].tx.wlen_m1 = 4'(wlen - 1);
        cfg[0].rx.late_fs = late;
        cfg[0].rx.fs_inv = inv;
        cfg[0].tx.fs_inv = inv;
        tx_data[0] = tx_w;
        tx_wr[0] = 1'b1;
        tick(1);
        tx_wr[0] = 1'b0;
        compare("tx_full", 16'h0001, {15'h0000, tx_full[0]});
        i_sport_far_end.xfer(wlen, late, inv, rx_w, got);
        tick(8);
        compare("tx_word", tx_e, got);
        compare("rx_word", rx_e, rx_data[0]);
        compare("rx_full", 16'h0001, {15'h0000, rx_full[0]});
        rx_rd[0] = 1'b1;
        tick(1);
        rx_rd[0] = 1'b0;
    endtask
    initial begin
        cfg = '0;
        pin_b = '1;
        tx_data = '0;
        tx_wr = '0;
        rx_rd = '0;
        alt_edge = 2'b10;
        alt_mode = 1'b0;
        flag_out = 1'b1;
        cfg[0].rx.en = 1'b1;
        cfg[0].rx.framed = 1'b1;
        cfg[0].tx.en = 1'b1;
        cfg[0].tx.framed = 1'b1;
        cfg[1].int_clk = 1'b1;
        cfg[1].clk_div = 8'h03;
        repeat (16) @(posedge clock_i);
        #1 srst_i = 1'b0;
        tick(2);
        for (int t = 0; t < 4; t++) begin
            word(lens[t], t[0], t[1], dual_sport_pkg::COMPAND_OFF);
            exp_w++;
            compare("tx_irqs", 16'(exp_w), 16'(wc[0]));
            compare("rx_irqs", 16'(exp_w), 16'(wc[1]));
            $display("word test %0d done", t);
        end
        cfg[0].autobuf = 1'b1;
        cfg[0].buf_len = 8'h02;
        for (int t = 0; t < 4; t++) begin
            word(8, 1'b0, 1'b0, dual_sport_pkg::COMPAND_OFF);
            compare("buf_irqs", 16'((t + 1) / 2), 16'(bc[1]));
            compare("tx_bufs", 16'((t + 1) / 2), 16'(bc[0]));
            compare("word_irqs", 16'(exp_w), 16'(wc[1]));
        end
        $display("buffer test done");
        cfg[0].autobuf = 1'b0;
        word(8, 1'b1, 1'b0, dual_sport_pkg::COMPAND_MU);
        word(8, 1'b0, 1'b1, dual_sport_pkg::COMPAND_A);
        exp_w += 2;
        compare("rx_irqs", 16'(exp_w), 16'(wc[1]));
        $display("compand test done");
        alt_mode = 1'b1;
        pin_b = '{sclk: 1'b0, rfs: 1'b0, tfs: 1'b1, dr: 1'b1};
        tick(6);
        compare("irq_zero", 16'h0001, {15'h0000, irq_zero});
        compare("flag_in", 16'h0001, {15'h0000, flag_in});
        compare("flag_pin", 16'h0003, {14'h0000, pin_out[1].dt_oe,
            pin_out[1].dt});
        pulses = 0;
        pin_b.tfs = 1'b0;
        tick(10);
        compare("irq_one", 16'h0001, 16'(pulses));
        alt_mode = 1'b0;
        tick(4);
        compare("flag_off", 16'h0000, {15'h0000, flag_in});
        $display("alternate test done");
        conclude();
    end
    initial begin
        #2000000;
        mismatches++;
        conclude();
    end
endmodule // tb
